/* rtl/afsf_pkg.sv */
// constants and types of the auxiliary-input string forwarder
// assumes a single 125 MHz clock domain
package afsf_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ  = 125_000_000;
  localparam int unsigned BAUD_BD = 9600;
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD_BD - 1) / BAUD_BD;

  // ****************************************
  // characters and string limits
  // ****************************************
  localparam int unsigned MAX_LEN    = 50;
  localparam logic [7:0]  CHR_CR     = 8'h0d;
  localparam logic [7:0]  CHR_SPACE  = 8'h20;
  localparam logic [7:0]  CHR_DEL    = 8'h7f;
  localparam logic [3:0]  AUX_STATUS = 4'h7;
  localparam logic [3:0]  OK_STATUS  = 4'h0;
  localparam logic [7:0]  DIAG_FILL  = 8'h00;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam int unsigned CTRL_AUX_BIT  = 0;
  localparam int unsigned CTRL_STEN_BIT = 1;
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_OVF_BIT  = 1;
  localparam int unsigned STAT_TRNC_BIT = 2;
  localparam logic        CTRL_AUX_RST  = 1'b0;
  localparam logic        CTRL_STEN_RST = 1'b1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} afsf_rx_t;
  typedef enum logic [1:0] {OUT_IDLE, OUT_FETCH, OUT_LOAD, OUT_HOLD} afsf_out_t;

endpackage

/* rtl/afsf_mem.sv */
// string store: one write port, one read port with registered data
// assumes write and read on the same clock
`timescale 1ns/1ns
`default_nettype none
module afsf_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 9
) (
  // clock
  input  wire logic          aclk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

/* rtl/afsf_top.sv */
// auxiliary-input string forwarder: serial receiver, string framer,
// string store and host result stream, with an axi4-lite register slave
// assumes aux_rxd and read_pulse come from pins; host side on aclk
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Function
// [RULE_01] manual code content enters only on the auxiliary serial line
// [RULE_02] forwarded strings use the normal result stream format
// [RULE_03] each forwarded string carries at most 50 characters
// [RULE_04] status field is 7 when status transmission is enabled
// [RULE_05] remaining diagnosis fields carry an arbitrary fill value
// [RULE_06] characters are received only while auxiliary-input mode is set
// [RULE_07] serial link runs 9600 baud, 8 data bits, no parity, 1 stop
// [RULE_08] carriage return closes a string; next character starts a new one
// [RULE_09] control characters other than carriage return are discarded
// [RULE_10] nothing received is echoed back to the sender
// [RULE_11] strings go to the host only after the reading pulse ends
// [RULE_12] sender puts only printable characters before the terminator
// [RULE_13] emulator start and stop framing characters are set to null
// [RULE_14] auxiliary-input mode is volatile, cleared by every reset
// [RULE_15] characters past fifty are dropped; empty strings queue nothing
module afsf_top
  import afsf_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC,
  parameter int unsigned AW         = 8
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // auxiliary serial line and reading pulse
  input  wire logic        aux_rxd,
  output var  logic        aux_txd,
  input  wire logic        read_pulse,
  // host result stream
  output var  logic        host_valid,
  input  wire logic        host_ready,
  output var  logic [7:0]  host_data,
  output var  logic        host_last,
  output var  logic [3:0]  result_status_field,
  output var  logic [7:0]  host_diag
);

  localparam int unsigned CW = $clog2(BIT_CYCLES);
  if (BIT_CYCLES < 4 || AW < 6 || AW > 16) begin
    $error("afsf_top: unsupported parameter values");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic          rxd_m;
    logic          rxd_s;
    logic          pls_m;
    logic          pls_s;
    afsf_rx_t      rx;
    logic [CW-1:0] cnt;
    logic [2:0]    bitn;
    logic [7:0]    sh;
    logic          aux_en;
    logic          st_en;
    logic          ovf;
    logic          trnc;
    logic          skip;
    logic [5:0]    len;
    logic [7:0]    last_chr;
    logic [AW-1:0] wp;
    logic [AW-1:0] wp_c;
    logic [AW-1:0] rp;
    logic [AW:0]   nstr;
    logic          mid;
    logic          we;
    logic [AW-1:0] wa;
    logic [8:0]    wd;
    afsf_out_t     out;
    logic          ov;
    logic [7:0]    od;
    logic          ol;
    logic [3:0]    os;
    logic          awr;
    logic          bv;
    logic [1:0]    br;
    logic          arr;
    logic          rv;
    logic [31:0]   rd;
    logic [1:0]    rr;
    logic          txd;
  } afsf_state_t;

  afsf_state_t q;
  afsf_state_t n;
  logic [8:0]  mem_rdata;
  logic        byte_ok;
  logic        is_ctrl;

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      REG_CTRL:  reg_sel = 2'h1;
      REG_STAT:  reg_sel = 2'h2;
      REG_COUNT: reg_sel = 2'h3;
      default:   reg_sel = 2'h0;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n        = q;
    n.we     = 1'b0;
    byte_ok  = 1'b0;
    // two-flop synchronisers, first stage read only by the second
    n.rxd_m  = aux_rxd;                                 // [RULE_01]
    n.rxd_s  = q.rxd_m;
    n.pls_m  = read_pulse;
    n.pls_s  = q.pls_m;
    n.txd    = 1'b1;                                    // [RULE_10]
    is_ctrl  = (q.sh < CHR_SPACE) || (q.sh == CHR_DEL);

    // register writes, before hardware sets so that sets win
    if (q.awr) begin
      n.awr = 1'b0;
      n.bv  = 1'b1;
      n.br  = (reg_sel(s_axi_awaddr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      if (s_axi_wstrb[0] && reg_sel(s_axi_awaddr) == 2'h1) begin
        n.aux_en = s_axi_wdata[CTRL_AUX_BIT];
        n.st_en  = s_axi_wdata[CTRL_STEN_BIT];
      end
      if (s_axi_wstrb[0] && reg_sel(s_axi_awaddr) == 2'h2) begin
        n.ovf  = q.ovf & ~s_axi_wdata[STAT_OVF_BIT];
        n.trnc = q.trnc & ~s_axi_wdata[STAT_TRNC_BIT];
      end
    end else if (!q.bv && s_axi_awvalid && s_axi_wvalid) begin
      n.awr = 1'b1;
    end
    if (q.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end

    // register reads
    if (q.arr) begin
      n.arr = 1'b0;
      n.rv  = 1'b1;
      n.rr  = RESP_OKAY;
      n.rd  = '0;
      case (reg_sel(s_axi_araddr))
        2'h1: begin
          n.rd[CTRL_AUX_BIT]  = q.aux_en;
          n.rd[CTRL_STEN_BIT] = q.st_en;
        end
        2'h2: begin
          n.rd[STAT_PEND_BIT] = (q.nstr != '0);
          n.rd[STAT_OVF_BIT]  = q.ovf;
          n.rd[STAT_TRNC_BIT] = q.trnc;
        end
        2'h3:    n.rd[AW:0] = q.nstr;
        default: n.rr = RESP_SLVERR;
      endcase
    end else if (!q.rv && s_axi_arvalid) begin
      n.arr = 1'b1;
    end
    if (q.rv && s_axi_rready) begin
      n.rv = 1'b0;
    end

    // serial receiver, 8 data bits, no parity, one stop bit
    case (q.rx)
      RX_IDLE: begin
        if (!q.rxd_s && q.aux_en) begin                 // [RULE_06]
          n.rx  = RX_START;
          n.cnt = CW'(BIT_CYCLES / 2);                  // [RULE_07]
        end
      end
      RX_START: begin
        if (q.cnt == '0) begin
          n.rx   = q.rxd_s ? RX_IDLE : RX_DATA;
          n.cnt  = CW'(BIT_CYCLES - 1);
          n.bitn = 3'h0;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      RX_DATA: begin
        if (q.cnt == '0) begin
          n.sh   = {q.rxd_s, q.sh[7:1]};                // [RULE_07]
          n.cnt  = CW'(BIT_CYCLES - 1);
          n.bitn = q.bitn + 1'b1;
          if (q.bitn == 3'h7) begin
            n.rx = RX_STOP;
          end
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      RX_STOP: begin
        if (q.cnt == '0) begin
          n.rx    = RX_IDLE;
          byte_ok = q.rxd_s;                            // framing error drops it
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      default: n.rx = RX_IDLE;
    endcase
    // string framing
    if (byte_ok) begin
      if (q.sh == CHR_CR) begin                         // [RULE_08]
        if (q.len != '0 && !q.skip) begin
          n.we   = 1'b1;
          n.wa   = q.wp - 1'b1;
          n.wd   = {1'b1, q.last_chr};
          n.wp_c = q.wp;
        end
        n.len  = '0;                                    // [RULE_15]
        n.skip = 1'b0;
      end else if (is_ctrl || q.skip) begin
        n.len = q.len;                                  // [RULE_09]
      end else if (q.len == 6'(MAX_LEN)) begin
        n.trnc = 1'b1;                                  // [RULE_03] [RULE_15]
      end else if (q.wp + 1'b1 == q.rp) begin
        n.ovf  = 1'b1;                                  // store full: drop string
        n.skip = 1'b1;
        n.wp   = q.wp_c;
        n.len  = '0;
      end else begin
        n.we       = 1'b1;
        n.wa       = q.wp;
        n.wd       = {1'b0, q.sh};
        n.wp       = q.wp + 1'b1;
        n.len      = q.len + 1'b1;
        n.last_chr = q.sh;
      end
    end
    // leaving the mode abandons a partly received string
    if (!q.aux_en) begin
      n.rx   = RX_IDLE;                                 // [RULE_06]
      n.wp   = q.wp_c;
      n.len  = '0;
      n.skip = 1'b0;
    end

    // result stream toward the host
    case (q.out)
      OUT_IDLE: begin
        if (q.rp != q.wp_c && (q.mid || !q.pls_s)) begin // [RULE_11]
          n.out = OUT_FETCH;
        end
      end
      OUT_FETCH: n.out = OUT_LOAD;
      OUT_LOAD: begin
        n.ov  = 1'b1;                                   // [RULE_02]
        n.od  = mem_rdata[7:0];
        n.ol  = mem_rdata[8];
        n.os  = q.st_en ? AUX_STATUS : OK_STATUS;       // [RULE_04]
        n.rp  = q.rp + 1'b1;
        n.mid = ~mem_rdata[8];
        n.out = OUT_HOLD;
      end
      OUT_HOLD: begin
        if (host_ready) begin
          n.ov  = 1'b0;
          n.out = OUT_IDLE;
        end
      end
      default: n.out = OUT_IDLE;
    endcase
    // count of whole strings held
    n.nstr = q.nstr + (AW+1)'(byte_ok && q.sh == CHR_CR && q.len != '0 && !q.skip)
                    - (AW+1)'(q.out == OUT_LOAD && mem_rdata[8]);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.aux_en <= CTRL_AUX_RST;                         // [RULE_14]
      q.st_en  <= CTRL_STEN_RST;
      q.rxd_m  <= 1'b1;
      q.rxd_s  <= 1'b1;
      q.txd    <= 1'b1;
    end else begin
      q <= n;
    end
  end

  afsf_mem #(
    .AW (AW),
    .DW (9)
  ) u_mem (
    .aclk  (aclk),
    .we    (q.we),
    .waddr (q.wa),
    .wdata (q.wd),
    .raddr (q.rp),
    .rdata (mem_rdata)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready       = q.awr;
  assign s_axi_wready        = q.awr;
  assign s_axi_bvalid        = q.bv;
  assign s_axi_bresp         = q.br;
  assign s_axi_arready       = q.arr;
  assign s_axi_rvalid        = q.rv;
  assign s_axi_rdata         = q.rd;
  assign s_axi_rresp         = q.rr;
  assign aux_txd             = q.txd;                   // [RULE_10]
  assign host_valid          = q.ov;
  assign host_data           = q.od;
  assign host_last           = q.ol;
  assign result_status_field = q.os;
  assign host_diag           = DIAG_FILL;               // [RULE_05]

  // ****************************************
  // checks
  // ****************************************
  tx_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    aux_txd == 1'b1) else $error("aux line driven away from idle");
  status_seven_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    $rose(host_valid) |-> result_status_field == ($past(q.st_en) ? 4'h7 : 4'h0))
    else $error("status field not set from enable");
  len_cap_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
    q.len <= 6'(MAX_LEN)) else $error("string longer than fifty");
  mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
    (q.rx == RX_IDLE && !q.aux_en) |=> q.rx == RX_IDLE)
    else $error("receiver started outside auxiliary mode");
  ctrl_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
    (byte_ok && is_ctrl && q.sh != CHR_CR) |=> q.wp == $past(q.wp) && !q.we)
    else $error("control character stored");
  pulse_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
    (q.out == OUT_IDLE && q.pls_s && !q.mid) |=> q.out == OUT_IDLE)
    else $error("string started during reading pulse");
  cr_commit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
    (byte_ok && q.aux_en && q.sh == CHR_CR && q.len != '0 && !q.skip)
    |=> q.wp_c == q.wp && q.len == '0 && q.we && q.wd[8])
    else $error("terminator did not close string");
  empty_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
    (byte_ok && q.sh == CHR_CR && q.len == '0) |=> $stable(q.wp_c))
    else $error("empty string queued");
  host_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
    (host_valid && !host_ready) |=> host_valid && $stable(host_data) && $stable(host_last))
    else $error("host result changed before taken");

endmodule
`default_nettype wire

/* verif/afsf_term_model.sv */
// terminal or hand scanner sending characters on the auxiliary line
// assumes the device samples the line on aclk; bit time in aclk cycles
`timescale 1ns/1ns
`default_nettype none
module afsf_term_model #(
  parameter int unsigned BITC = 16
) (
  // clock
  input  wire logic aclk,
  // serial line toward the device
  output var  logic txd
);
  // ****
  // sender
  // ****
  initial txd = 1'b1; // line rests at mark between characters

  // start bit, eight data bits lsb first, no parity, one stop
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      txd <= f[i];
      repeat (BITC - 1) @(posedge aclk);
    end
  endtask

  // printable data, optional null framing, then terminator
  task automatic send_str(input string s, input bit nul, input bit cr);
    if (nul) send_char(8'h00);
    for (int i = 0; i < s.len(); i++) send_char(s[i]);
    if (cr) send_char(8'h0d);
    if (nul) send_char(8'h00);
  endtask
endmodule
`default_nettype wire

/* verif/aux_input_string_forwarder_tb.sv */
// self-checking bench of the auxiliary-input string forwarder
// assumes afsf_pkg compiled first; short bit time for run length
`timescale 1ns/1ns
`default_nettype none
module aux_input_string_forwarder_tb import afsf_pkg::*;;
  localparam int unsigned BITC = 16;
  // ceiling: some 70 characters of 160 cycles each, plus bus and stream traffic
  localparam int unsigned CYC_MAX = 40000;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, host_data, host_diag;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, result_status_field;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        aux_rxd, aux_txd, read_pulse, host_valid, host_ready, host_last;
  int          mismatches, n_tests, cyc;

  afsf_top #(.BIT_CYCLES(BITC)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_rxd, .aux_txd, .read_pulse,
    .host_valid, .host_ready, .host_data, .host_last, .result_status_field, .host_diag
  );
  afsf_term_model #(.BITC(BITC)) u_term (.aclk(aclk), .txd(aux_rxd));

  // ****
  // clock, host stall pattern
  // ****
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;
  // host stalls every other cycle so held outputs get exercised
  always @(posedge aclk) host_ready <= (host_ready !== 1'b1);

  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // let an edge pass so a following call never re-drives in this step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // collects one string from the host stream and judges each beat
  task automatic recv(input string s, input logic [3:0] st);
    int w;
    for (int i = 0; i < s.len(); i++) begin
      w = 0;
      do begin
        @(posedge aclk);
        w++;
      end while (!(host_valid === 1'b1 && host_ready === 1'b1) && w < 400);
      chk(host_data, s[i]);
      chk(host_last, i == s.len() - 1);
      chk(result_status_field, st);
      chk(host_diag, DIAG_FILL);
    end
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    axi_rd(REG_CTRL);
    chk(rd, 32'h2);
    axi_rd(8'h0c);
    chk(rsp, RESP_SLVERR);
    axi_wr(8'h0c, 32'h3);
    chk(rsp, RESP_SLVERR);
    axi_rd(REG_CTRL);
    chk(rd, 32'h2);
    $display("test regs done");
  endtask

  task automatic t_mode_off();
    u_term.send_str("AB", 1'b0, 1'b1);
    repeat (20) @(posedge aclk);
    axi_rd(REG_COUNT);
    chk(rd, 32'h0);
    chk(host_valid, 1'b0);
    $display("test mode_off done");
  endtask

  task automatic t_pulse();
    axi_wr(REG_CTRL, 32'h3);
    read_pulse <= 1'b1;
    u_term.send_str("12", 1'b1, 1'b0);
    u_term.send_char(8'h01); // stray control in mid-string
    u_term.send_str("3", 1'b0, 1'b1);
    u_term.send_str("", 1'b1, 1'b1); // empty line queues nothing
    repeat (40) @(posedge aclk);
    chk(host_valid, 1'b0);
    axi_rd(REG_COUNT);
    chk(rd, 32'h1);
    read_pulse <= 1'b0;
    recv("123", AUX_STATUS);
    chk(aux_txd, 1'b1);
    $display("test pulse done");
  endtask

  task automatic t_long();
    string e;
    e = "";
    for (int i = 0; i < 5; i++) e = {e, "0123456789"};
    u_term.send_str({e, "ab"}, 1'b0, 1'b1);
    // stream starts right after the terminator, so collect it before polling
    recv(e, AUX_STATUS);
    axi_rd(REG_STAT);
    chk(rd[STAT_TRNC_BIT], 1'b1);
    $display("test long done");
  endtask

  task automatic t_sten();
    axi_wr(REG_CTRL, 32'h1);
    u_term.send_str("9", 1'b0, 1'b1);
    recv("9", OK_STATUS);
    $display("test status_off done");
  endtask

  task automatic t_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CTRL);
    chk(rd, 32'h2);
    u_term.send_str("5", 1'b0, 1'b1);
    repeat (20) @(posedge aclk);
    axi_rd(REG_COUNT);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    aresetn = 1'b0; read_pulse = 1'b0;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; mismatches = 0; n_tests = 0; cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fork
      begin
        t_regs();
        t_mode_off();
        t_pulse();
        t_long();
        t_sten();
        t_reset();
      end
      begin
        while (cyc < CYC_MAX) begin
          @(posedge aclk);
          cyc++;
        end
        mismatches++;
        $display("Error at %0t: cycles %h reached limit %h", $time, cyc, CYC_MAX);
      end
    join_any
    print_verdict();
  end
endmodule
`default_nettype wire
